// ---- hw/dcmbx_box.sv ----
// one mailbox: two data words and the pending flag that locks them
`timescale 1ns/1ps
`default_nettype none
`include "dcmbx_defines.svh"
module dcmbx_box
    import dcmbx_pkg::*;
#(
    parameter int DATA_W = `DCMBX_DATA_W
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              wr_first,
    input  wire logic              wr_second,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              rd_second_rcv,
    output logic      [DATA_W-1:0] first_q,
    output logic      [DATA_W-1:0] second_q,
    output logic                   pending_q
);
    logic [DATA_W-1:0] first_d;
    logic [DATA_W-1:0] second_d;
    logic              pending_d;

    always_comb begin
        first_d   = first_q;
        second_d  = second_q;
        pending_d = pending_q;
        if (wr_first && !pending_q) begin // RULE5
            first_d = wdata;
        end
        if (rd_second_rcv) begin // RULE3
            pending_d = 1'b0;
        end
        // set after clear so a new message is never lost
        if (wr_second && !pending_q) begin // RULE5
            second_d  = wdata;
            pending_d = 1'b1; // RULE2
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            first_q   <= `DCMBX_DATA_RESET; // RULE17
            second_q  <= `DCMBX_DATA_RESET; // RULE17
            pending_q <= 1'b0;
        end else begin
            first_q   <= first_d;
            second_q  <= second_d;
            pending_q <= pending_d;
        end
    end
endmodule
`default_nettype wire

// ---- hw/dcmbx_defines.svh ----
// register offsets, field positions, reset values and box numbering of the dual-core mailbox
`ifndef DCMBX_DEFINES_SVH
`define DCMBX_DEFINES_SVH

`define DCMBX_DATA_W        16
`define DCMBX_ADDR_W        6
`define DCMBX_NUM_BOX       4
`define DCMBX_DATA_RESET    16'h0000
`define DCMBX_FLAG_BIT      0

`define DCMBX_OFS_H2D1_FIRST   6'h00
`define DCMBX_OFS_H2D1_SECOND  6'h04
`define DCMBX_OFS_D2H1_FIRST   6'h08
`define DCMBX_OFS_D2H1_SECOND  6'h0C
`define DCMBX_OFS_D2H2_FIRST   6'h10
`define DCMBX_OFS_D2H2_SECOND  6'h14
`define DCMBX_OFS_H2D1_PEND    6'h18
`define DCMBX_OFS_D2H1_PEND    6'h1C
`define DCMBX_OFS_D2H2_PEND    6'h20
`define DCMBX_OFS_H2D2_FIRST   6'h24
`define DCMBX_OFS_H2D2_SECOND  6'h28
`define DCMBX_OFS_H2D2_PEND    6'h2C

`define DCMBX_BOX_H2D1      2'h0
`define DCMBX_BOX_D2H1      2'h1
`define DCMBX_BOX_D2H2      2'h2
`define DCMBX_BOX_H2D2      2'h3
`define DCMBX_HOST_SENDS    4'h9

`endif

// ---- hw/dcmbx_pkg.sv ----
// types shared by the dual-core mailbox modules
package dcmbx_pkg;
`include "dcmbx_defines.svh"

    typedef enum logic [1:0] {
        DCMBX_KIND_NONE,
        DCMBX_KIND_FIRST,
        DCMBX_KIND_SECOND,
        DCMBX_KIND_FLAG
    } dcmbx_kind_t;

    typedef struct packed {
        logic                       sel;
        logic                       wr;
        logic [`DCMBX_ADDR_W-1:0]   addr;
        logic [`DCMBX_DATA_W-1:0]   wdata;
    } dcmbx_req_t;

    typedef struct packed {
        logic [1:0]                 box;
        dcmbx_kind_t                kind;
    } dcmbx_dec_t;

    typedef struct packed {
        logic                       done;
        logic                       abort;
        logic [`DCMBX_DATA_W-1:0]   rdata;
    } dcmbx_rsp_t;

endpackage

// ---- hw/dcmbx_resp.sv ----
// registered answer stage of one access port
`timescale 1ns/1ps
`default_nettype none
`include "dcmbx_defines.svh"
module dcmbx_resp
    import dcmbx_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire dcmbx_req_t req,
    input  wire logic       abort_now,
    input  wire logic [`DCMBX_DATA_W-1:0] rdata_now,
    output var dcmbx_rsp_t  rsp_q
);
    dcmbx_rsp_t rsp_d;

    always_comb begin
        rsp_d       = '0;
        rsp_d.done  = req.sel;
        rsp_d.abort = req.sel && req.wr && abort_now; // RULE6
        if (req.sel && !req.wr) begin
            rsp_d.rdata = rdata_now;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_q <= '0;
        end else begin
            rsp_q <= rsp_d;
        end
    end
endmodule
`default_nettype wire

// ---- hw/dcmbx_top.sv ----
// dual-core mailbox: host-side and dsp-side register ports, four mailboxes, interrupt lines
// Notes on behaviour
// RULE1 - host write of a host-to-dsp second word interrupts the dsp; first word does not
// RULE2 - writing a second word sets that mailbox's pending flag
// RULE3 - receiver reading the second word clears the pending flag
// RULE4 - sender reading the second word leaves the flag alone
// RULE5 - while pending, sender writes to either data word are dropped
// RULE6 - a dropped write answers the writer with a time-out abort
// RULE7 - sender can still read its own locked data words
// RULE8 - flag registers are read only; writes do nothing
// RULE9 - sender writes first word before second; second write locks the mailbox
// RULE10 - sender polls the flag and starts a new message only once cleared
// RULE11 - software enables each mailbox interrupt as level sensitive before use
// RULE12 - interrupt is a level held until the receiver's read; masking never cancels it
// RULE13 - two dsp-to-host mailboxes interrupt the host with the same lock sequence
// RULE14 - each direction written only by its sender, read by its receiver
// RULE15 - each register holds 16 data bits on a 32-bit aligned word
// RULE16 - twelve registers at fixed word offsets from the mailbox base
// RULE17 - all data words reset to zero
// RULE18 - pending flag sits in bit 0 of its flag register, other bits zero
`timescale 1ns/1ps
`default_nettype none
`include "dcmbx_defines.svh"
module dcmbx_top
    import dcmbx_pkg::*;
#(
    parameter int DATA_W = `DCMBX_DATA_W, // RULE15
    parameter int ADDR_W = `DCMBX_ADDR_W
) (
    input  wire logic              MCLK,
    input  wire logic              RST,
    input  wire logic              H_SEL,
    input  wire logic              H_WR,
    input  wire logic [ADDR_W-1:0] H_ADDR,
    input  wire logic [DATA_W-1:0] H_WDATA,
    output logic      [DATA_W-1:0] H_RDATA,
    output logic                   H_DONE,
    output logic                   H_ABORT,
    input  wire logic              D_SEL,
    input  wire logic              D_WR,
    input  wire logic [ADDR_W-1:0] D_ADDR,
    input  wire logic [DATA_W-1:0] D_WDATA,
    output logic      [DATA_W-1:0] D_RDATA,
    output logic                   D_DONE,
    output logic                   D_ABORT,
    output logic      [1:0]        DSP_IRQ,
    output logic      [1:0]        HOST_IRQ
);
    localparam int NB = `DCMBX_NUM_BOX;
    localparam logic [NB-1:0] HOST_SENDS = `DCMBX_HOST_SENDS;

    dcmbx_req_t        h_req;
    dcmbx_req_t        d_req;
    dcmbx_dec_t        h_dec;
    dcmbx_dec_t        d_dec;
    dcmbx_rsp_t        h_rsp_q;
    dcmbx_rsp_t        d_rsp_q;
    logic [NB-1:0]     box_wr_first;
    logic [NB-1:0]     box_wr_second;
    logic [NB-1:0]     box_rd_rcv;
    logic [NB-1:0]     pending_q;
    logic [DATA_W-1:0] box_wdata  [NB];
    logic [DATA_W-1:0] first_q    [NB];
    logic [DATA_W-1:0] second_q   [NB];
    logic              h_abort_now;
    logic              d_abort_now;
    logic [DATA_W-1:0] h_rdata_now;
    logic [DATA_W-1:0] d_rdata_now;

    // fixed offset map; misaligned or unlisted offsets decode as no register
    function automatic dcmbx_dec_t reg_decode(input logic [ADDR_W-1:0] addr);
        dcmbx_dec_t dec;
        dec.box  = 2'h0;
        dec.kind = DCMBX_KIND_NONE;
        case (addr) // RULE16
            `DCMBX_OFS_H2D1_FIRST: begin
                dec.box  = `DCMBX_BOX_H2D1;
                dec.kind = DCMBX_KIND_FIRST;
            end
            `DCMBX_OFS_H2D1_SECOND: begin
                dec.box  = `DCMBX_BOX_H2D1;
                dec.kind = DCMBX_KIND_SECOND;
            end
            `DCMBX_OFS_D2H1_FIRST: begin
                dec.box  = `DCMBX_BOX_D2H1;
                dec.kind = DCMBX_KIND_FIRST;
            end
            `DCMBX_OFS_D2H1_SECOND: begin
                dec.box  = `DCMBX_BOX_D2H1;
                dec.kind = DCMBX_KIND_SECOND;
            end
            `DCMBX_OFS_D2H2_FIRST: begin
                dec.box  = `DCMBX_BOX_D2H2;
                dec.kind = DCMBX_KIND_FIRST;
            end
            `DCMBX_OFS_D2H2_SECOND: begin
                dec.box  = `DCMBX_BOX_D2H2;
                dec.kind = DCMBX_KIND_SECOND;
            end
            `DCMBX_OFS_H2D1_PEND: begin
                dec.box  = `DCMBX_BOX_H2D1;
                dec.kind = DCMBX_KIND_FLAG;
            end
            `DCMBX_OFS_D2H1_PEND: begin
                dec.box  = `DCMBX_BOX_D2H1;
                dec.kind = DCMBX_KIND_FLAG;
            end
            `DCMBX_OFS_D2H2_PEND: begin
                dec.box  = `DCMBX_BOX_D2H2;
                dec.kind = DCMBX_KIND_FLAG;
            end
            `DCMBX_OFS_H2D2_FIRST: begin
                dec.box  = `DCMBX_BOX_H2D2;
                dec.kind = DCMBX_KIND_FIRST;
            end
            `DCMBX_OFS_H2D2_SECOND: begin
                dec.box  = `DCMBX_BOX_H2D2;
                dec.kind = DCMBX_KIND_SECOND;
            end
            `DCMBX_OFS_H2D2_PEND: begin
                dec.box  = `DCMBX_BOX_H2D2;
                dec.kind = DCMBX_KIND_FLAG;
            end
            default: begin
                dec.box  = 2'h0;
                dec.kind = DCMBX_KIND_NONE;
            end
        endcase
        return dec;
    endfunction

    // both sides may read every register, locked or not
    function automatic logic [DATA_W-1:0] reg_read(input dcmbx_dec_t dec,
                                                   input logic [DATA_W-1:0] fw,
                                                   input logic [DATA_W-1:0] sw,
                                                   input logic pend);
        logic [DATA_W-1:0] val;
        val = '0;
        case (dec.kind)
            DCMBX_KIND_FIRST:  val = fw; // RULE7
            DCMBX_KIND_SECOND: val = sw; // RULE7
            DCMBX_KIND_FLAG:   val[`DCMBX_FLAG_BIT] = pend; // RULE18
            default:           val = '0;
        endcase
        return val;
    endfunction

    // a data access by the owning side that hits a locked mailbox; dcmbx_resp keeps only the writes
    function automatic logic locked_hit(input dcmbx_dec_t dec,
                                        input logic owner,
                                        input logic pend);
        logic hit;
        hit = 1'b0;
        if (owner && pend &&
            (dec.kind == DCMBX_KIND_FIRST || dec.kind == DCMBX_KIND_SECOND)) begin
            hit = 1'b1; // RULE5
        end
        return hit;
    endfunction

    always_comb begin
        h_req.sel   = H_SEL;
        h_req.wr    = H_WR;
        h_req.addr  = H_ADDR;
        h_req.wdata = H_WDATA;
        d_req.sel   = D_SEL;
        d_req.wr    = D_WR;
        d_req.addr  = D_ADDR;
        d_req.wdata = D_WDATA;
        h_dec       = reg_decode(H_ADDR);
        d_dec       = reg_decode(D_ADDR);
    end

    // per-box strobes; only the sender's writes reach a box, flag offsets fall through
    always_comb begin // RULE8
        for (int b = 0; b < NB; b++) begin
            logic h_here;
            logic d_here;
            h_here = h_req.sel && (h_dec.box == 2'(b));
            d_here = d_req.sel && (d_dec.box == 2'(b));
            if (HOST_SENDS[b]) begin
                // host-to-dsp box: host writes, dsp reads and clears
                box_wr_first[b]  = h_here && h_req.wr && h_dec.kind == DCMBX_KIND_FIRST; // RULE14
                box_wr_second[b] = h_here && h_req.wr && h_dec.kind == DCMBX_KIND_SECOND; // RULE1
                box_rd_rcv[b]    = d_here && !d_req.wr && d_dec.kind == DCMBX_KIND_SECOND; // RULE4
                box_wdata[b]     = h_req.wdata;
            end else begin
                // dsp-to-host box: the same sequence, roles swapped
                box_wr_first[b]  = d_here && d_req.wr && d_dec.kind == DCMBX_KIND_FIRST; // RULE14
                box_wr_second[b] = d_here && d_req.wr && d_dec.kind == DCMBX_KIND_SECOND; // RULE13
                box_rd_rcv[b]    = h_here && !h_req.wr && h_dec.kind == DCMBX_KIND_SECOND; // RULE4
                box_wdata[b]     = d_req.wdata;
            end
        end
    end

    for (genvar g = 0; g < NB; g++) begin : g_box
        dcmbx_box #(
            .DATA_W        (DATA_W)
        ) u_box (
            .clk           (MCLK),
            .rst           (RST),
            .wr_first      (box_wr_first[g]),
            .wr_second     (box_wr_second[g]),
            .wdata         (box_wdata[g]),
            .rd_second_rcv (box_rd_rcv[g]),
            .first_q       (first_q[g]),
            .second_q      (second_q[g]),
            .pending_q     (pending_q[g])
        );
    end

    // flag writes and writes by the non-owning side are dropped silently
    always_comb begin
        h_rdata_now = reg_read(h_dec, first_q[h_dec.box], second_q[h_dec.box], pending_q[h_dec.box]);
        d_rdata_now = reg_read(d_dec, first_q[d_dec.box], second_q[d_dec.box], pending_q[d_dec.box]);
        h_abort_now = locked_hit(h_dec, HOST_SENDS[h_dec.box], pending_q[h_dec.box]); // RULE6
        d_abort_now = locked_hit(d_dec, !HOST_SENDS[d_dec.box], pending_q[d_dec.box]); // RULE6
    end

    dcmbx_resp u_host_resp (
        .clk       (MCLK),
        .rst       (RST),
        .req       (h_req),
        .abort_now (h_abort_now),
        .rdata_now (h_rdata_now),
        .rsp_q     (h_rsp_q)
    );

    dcmbx_resp u_dsp_resp (
        .clk       (MCLK),
        .rst       (RST),
        .req       (d_req),
        .abort_now (d_abort_now),
        .rdata_now (d_rdata_now),
        .rsp_q     (d_rsp_q)
    );

    // interrupts are the pending flags themselves: a level, so a masked one is never lost
    always_comb begin
        H_RDATA  = h_rsp_q.rdata;
        H_DONE   = h_rsp_q.done;
        H_ABORT  = h_rsp_q.abort;
        D_RDATA  = d_rsp_q.rdata;
        D_DONE   = d_rsp_q.done;
        D_ABORT  = d_rsp_q.abort;
        DSP_IRQ  = {pending_q[`DCMBX_BOX_H2D2], pending_q[`DCMBX_BOX_H2D1]}; // RULE12
        HOST_IRQ = {pending_q[`DCMBX_BOX_D2H2], pending_q[`DCMBX_BOX_D2H1]}; // RULE12
    end
endmodule
`default_nettype wire

// ---- verif/dcmbx_cpu_model.sv ----
// behavioural processor port issuing mailbox accesses
`timescale 1ns/1ps
`default_nettype none
module dcmbx_cpu_model (
    input  wire logic        clk,
    output logic             sel,
    output logic             wr,
    output logic [5:0]       addr,
    output logic [15:0]      wdata
);
    initial begin
        sel = 1'h0;
        wr = 1'h0;
        addr = 6'h00;
        wdata = 16'h0000;
    end
    // the task enforces no order; the bench writes first word before second but also writes to locked boxes and a lone second word
    task automatic drive(input logic w, input logic [5:0] a, input logic [15:0] d);
        sel = 1'h1;
        wr = w;
        addr = a;
        wdata = d;
        @(negedge clk);
    endtask
    // a released bus shows inverted data so a stale value cannot pass for a held one
    task automatic rel();
        sel = 1'h0;
        wdata = ~wdata;
    endtask
endmodule
`default_nettype wire

// ---- verif/dcmbx_top_sva.sv ----
// port-level checker for the dual-core mailbox
`timescale 1ns/1ps
`default_nettype none
module dcmbx_chk #(
    parameter int DATA_W = 16,
    parameter int ADDR_W = 6
) (
    input wire logic              MCLK,
    input wire logic              RST,
    input wire logic              H_SEL,
    input wire logic              H_WR,
    input wire logic [ADDR_W-1:0] H_ADDR,
    input wire logic [DATA_W-1:0] H_RDATA,
    input wire logic              H_DONE,
    input wire logic              H_ABORT,
    input wire logic              D_SEL,
    input wire logic              D_WR,
    input wire logic [ADDR_W-1:0] D_ADDR,
    input wire logic              D_DONE,
    input wire logic              D_ABORT,
    input wire logic [1:0]        DSP_IRQ,
    input wire logic [1:0]        HOST_IRQ
);
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (RST);

    chk_host_answer: assert property (H_SEL |=> H_DONE) else $error("host access not answered");
    chk_dsp_idle: assert property (!D_SEL |=> !D_DONE && !D_ABORT) else $error("dsp answer without access");
    chk_first_quiet: assert property (H_SEL && H_WR && H_ADDR == 6'h00 && !DSP_IRQ[0] |=> !DSP_IRQ[0])
        else $error("first word raised interrupt");
    chk_second_raises: assert property (H_SEL && H_WR && H_ADDR == 6'h28 && !(D_SEL && !D_WR && D_ADDR == 6'h28)
        |=> DSP_IRQ[1]) else $error("second word left interrupt low");
    chk_dsp_raises: assert property (D_SEL && D_WR && D_ADDR == 6'h0C && !(H_SEL && !H_WR && H_ADDR == 6'h0C)
        |=> HOST_IRQ[0]) else $error("dsp second word left host interrupt low");
    chk_rcv_clears: assert property (DSP_IRQ[0] && D_SEL && !D_WR && D_ADDR == 6'h04 |=> !DSP_IRQ[0])
        else $error("receiver read left flag set");
    chk_irq_holds: assert property (HOST_IRQ[1] && !(H_SEL && !H_WR && H_ADDR == 6'h14) |=> HOST_IRQ[1])
        else $error("interrupt dropped without receiver read");
    chk_locked_abort: assert property (DSP_IRQ[0] && H_SEL && H_WR && (H_ADDR == 6'h00 || H_ADDR == 6'h04)
        |=> H_ABORT && H_DONE) else $error("locked write not aborted");
    chk_abort_cause: assert property (H_ABORT |-> $past(DSP_IRQ) != 2'h0) else $error("abort with no lock");
    chk_flag_bit: assert property (H_SEL && !H_WR && H_ADDR == 6'h18
        |=> H_RDATA == {15'h0000, $past(DSP_IRQ[0])}) else $error("flag register value wrong");
endmodule

bind dcmbx_top dcmbx_chk #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_chk (.MCLK, .RST, .H_SEL, .H_WR, .H_ADDR,
    .H_RDATA, .H_DONE, .H_ABORT, .D_SEL, .D_WR, .D_ADDR, .D_DONE, .D_ABORT, .DSP_IRQ, .HOST_IRQ);
`default_nettype wire

// ---- verif/dcmbx_top_tb.sv ----
// self-checking bench for the dual-core mailbox
`timescale 1ns/1ps
`default_nettype none
module dcmbx_top_tb;
    logic        MCLK = 1'h0;
    logic        RST = 1'h1;
    logic        hs, hw, ds, dw, hdn, hab, ddn, dab;
    logic [5:0]  ha, da;
    logic [15:0] hd, dd, hr, dr, a, b;
    logic [1:0]  dirq, hirq;
    logic [3:0]  irq;
    logic [16:0] qh[$];
    logic [16:0] qd[$];
    logic [5:0]  fo[4] = '{6'h00, 6'h08, 6'h10, 6'h24};
    logic [5:0]  so[4] = '{6'h04, 6'h0C, 6'h14, 6'h28};
    logic [5:0]  po[4] = '{6'h18, 6'h1C, 6'h20, 6'h2C};
    int          ib[4] = '{0, 2, 3, 1};
    bit          snd[4] = '{1, 0, 0, 1};
    int          n_mismatch = 0;
    int          check_count = 0;

    assign irq = {hirq, dirq};
    always #2.5 MCLK = ~MCLK;

    dcmbx_top dut (.MCLK(MCLK), .RST(RST), .H_SEL(hs), .H_WR(hw), .H_ADDR(ha), .H_WDATA(hd), .H_RDATA(hr),
        .H_DONE(hdn), .H_ABORT(hab), .D_SEL(ds), .D_WR(dw), .D_ADDR(da), .D_WDATA(dd), .D_RDATA(dr),
        .D_DONE(ddn), .D_ABORT(dab), .DSP_IRQ(dirq), .HOST_IRQ(hirq));
    dcmbx_cpu_model h_m (.clk(MCLK), .sel(hs), .wr(hw), .addr(ha), .wdata(hd));
    dcmbx_cpu_model d_m (.clk(MCLK), .sel(ds), .wr(dw), .addr(da), .wdata(dd));

    task automatic cmp(input string nm, input logic [16:0] e, input logic [16:0] g);
        check_count++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    // writes answer zero data; the other port is released so it issues nothing more
    task automatic acc(input bit h, input logic w, input logic [5:0] ad, input logic [15:0] d,
                       input logic [15:0] er, input logic ea);
        if (h) begin
            qh.push_back({ea, er});
            d_m.rel();
            h_m.drive(w, ad, d);
        end else begin
            qd.push_back({ea, er});
            h_m.rel();
            d_m.drive(w, ad, d);
        end
    endtask

    task automatic gap();
        h_m.rel();
        d_m.rel();
        @(negedge MCLK);
    endtask

    task automatic chk_reset();
        for (int i = 0; i < 4; i++) begin
            acc(1'h1, 1'h0, fo[i], 16'h0000, 16'h0000, 1'h0);
            acc(1'h1, 1'h0, so[i], 16'h0000, 16'h0000, 1'h0);
            acc(1'h1, 1'h0, po[i], 16'h0000, 16'h0000, 1'h0);
        end
        gap();
    endtask

    task automatic conclude();
        cmp("answers left", 17'h00000, 17'(qh.size() + qd.size()));
        $display("mismatches %0d checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // each answer is paired with the oldest expectation of its port
    always @(negedge MCLK) begin
        if (hdn === 1'h1) begin
            cmp("host answer", qh.size() != 0 ? qh.pop_front() : 17'h1FFFF, {hab, hr});
        end
        if (ddn === 1'h1) begin
            cmp("dsp answer", qd.size() != 0 ? qd.pop_front() : 17'h1FFFF, {dab, dr});
        end
    end

    initial begin
        #20000;
        n_mismatch++;
        conclude();
    end

    initial begin
        void'($urandom(69));
        repeat (5) @(negedge MCLK);
        RST = 1'h0;
        chk_reset();
        acc(1'h1, 1'h0, 6'h30, 16'h0000, 16'h0000, 1'h0);
        acc(1'h1, 1'h1, 6'h02, 16'h1234, 16'h0000, 1'h0);
        for (int i = 0; i < 4; i++) begin
            a = 16'($urandom);
            b = 16'($urandom);
            acc(snd[i], 1'h1, fo[i], a, 16'h0000, 1'h0);
            cmp("irq", 17'h00000, {16'h0000, irq[ib[i]]});
            acc(snd[i], 1'h1, so[i], b, 16'h0000, 1'h0);
            cmp("irq", 17'h00001, {16'h0000, irq[ib[i]]});
            acc(snd[i], 1'h1, fo[i], ~a, 16'h0000, 1'h1);
            acc(snd[i], 1'h1, so[i], ~b, 16'h0000, 1'h1);
            acc(snd[i], 1'h0, fo[i], 16'h0000, a, 1'h0);
            acc(snd[i], 1'h0, so[i], 16'h0000, b, 1'h0);
            acc(snd[i], 1'h0, po[i], 16'h0000, 16'h0001, 1'h0);
            acc(!snd[i], 1'h1, fo[i], ~a, 16'h0000, 1'h0);
            acc(!snd[i], 1'h1, po[i], 16'h0000, 16'h0000, 1'h0);
            acc(!snd[i], 1'h0, po[i], 16'h0000, 16'h0001, 1'h0);
            gap();
            repeat (6) @(negedge MCLK);
            // interrupt lines are read as levels, as a level-sensitive controller would
            cmp("irq", 17'h00001, {16'h0000, irq[ib[i]]});
            acc(!snd[i], 1'h0, fo[i], 16'h0000, a, 1'h0);
            acc(!snd[i], 1'h0, so[i], 16'h0000, b, 1'h0);
            cmp("irq", 17'h00000, {16'h0000, irq[ib[i]]});
            acc(snd[i], 1'h0, po[i], 16'h0000, 16'h0000, 1'h0);
            gap();
        end
        acc(1'h1, 1'h1, 6'h04, 16'h5A5A, 16'h0000, 1'h0);
        gap();
        RST = 1'h1;
        repeat (2) @(negedge MCLK);
        RST = 1'h0;
        chk_reset();
        conclude();
    end
endmodule
`default_nettype wire
